// >>> include/rcl_consts.svh
// Constants for the reclocker output and rate control block
// Functional notes
// - Mute drives outputs to the mute level, low at reset
// - Mute beats bypass
// - Mute pin active low
// - Register mute unless override
// - Mute level bit mutes high
// - Bypass passes raw data
// - Unsupported rate forces bypass
// - No lock during bypass
// - Bypass pin active high
// - Register bypass; eye monitor off
// - Clock output mutes unless locked
// - Clock enable from pin or register
// - Lock picks reclocked data
// - Override selects outputs by field
// - Override keeps only bypass bit
// - Primary select codes
// - Secondary select codes
// - Rate codes limit lock
// - Rate register overrides pins
// - Reference presence and fraction
// - Standard flag only locked 270
// - Lock on pin and register
// - Mode pin picks control source
`ifndef RCL_CONSTS_SVH
`define RCL_CONSTS_SVH

// ==========================================================
// Register offsets
`define RCL_ADDR_LOCK_STATUS     7'h01
`define RCL_ADDR_OVERRIDE_CTRL   7'h09
`define RCL_ADDR_FUNCTION_CTRL   7'h12
`define RCL_ADDR_MUX_MUTE_CTRL   7'h14
`define RCL_ADDR_LOCK_RATE_SEL   7'h1c
`define RCL_ADDR_LOCK_RATE_OV    7'h1d
`define RCL_ADDR_MANUAL_SEL      7'h1e
`define RCL_ADDR_REF_STATUS      7'h41

// ==========================================================
// Field positions
`define RCL_BIT_MANUAL_OV        5
`define RCL_BIT_BYPASS           2
`define RCL_BIT_MUTE             1
`define RCL_BIT_CLK_EN           0
`define RCL_BIT_MUTE_LEVEL       7
`define RCL_BIT_RATE_OV          0
`define RCL_BIT_LOCK             4
`define RCL_BIT_REF_PRESENT      3
`define RCL_BIT_ONE_OVER_M       2
`define RCL_PRI_SEL_HI           6
`define RCL_PRI_SEL_LO           5
`define RCL_SEC_SEL_HI           4
`define RCL_SEC_SEL_LO           3

// ==========================================================
// Reset values
`define RCL_REG_RESET            8'h00

// ==========================================================
// Locked rate code meaning 270 Mbps
`define RCL_RATE_CODE_270        3'h1

// ==========================================================
// Frame: read flag, 7 address bits, 8 data bits
`define RCL_FRAME_BITS           5'h10
`define RCL_HEADER_BITS          5'h08

// ==========================================================
// Reference detection timing
`define RCL_CLK_PERIOD_NS        8
`define RCL_REF_WINDOW_NS        8192
`define RCL_REF_WINDOW_CYCLES    (`RCL_REF_WINDOW_NS / `RCL_CLK_PERIOD_NS)
`define RCL_REF_FREQ_MHZ         27
`define RCL_REF_MIN_EDGES        ((`RCL_REF_WINDOW_NS * `RCL_REF_FREQ_MHZ / 1000) / 2)

`endif

// >>> include/rcl_pkg.sv
// Types shared by the reclocker output and rate control block
package rcl_pkg;

  // ========================================================
  // Source driven onto a serial output
  typedef enum logic [1:0] {
    RCL_SRC_MUTED     = 2'h0,
    RCL_SRC_BYPASSED  = 2'h1,
    RCL_SRC_RECLOCKED = 2'h2,
    RCL_SRC_CLOCK     = 2'h3
  } rcl_src_e;

  // ========================================================
  // Allowed lock rate groups
  typedef enum logic [1:0] {
    RCL_RATE_AUTO    = 2'h0,
    RCL_RATE_SD270   = 2'h1,
    RCL_RATE_HD3G    = 2'h2,
    RCL_RATE_MADI125 = 2'h3
  } rcl_rate_e;

  // ========================================================
  // Register write queued from the serial port
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
  } rcl_wr_s;

  // ========================================================
  // Data streams arriving from the analog front end
  typedef struct packed {
    logic bypassData;
    logic reclockedData;
    logic recoveredClock;
  } rcl_stream_s;

endpackage

// >>> verilog/rcl_output_rate_control.sv
// Output routing, rate select and register control of the reclocker
`timescale 1ns/100ps
`include "rcl_consts.svh"

// ============================================================
// Write queue between the serial port and the register file
module rcl_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 4
) (
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               rdPtr;
    logic [PW-1:0]               wrPtr;
    logic [PW:0]                 count;
  } rcl_fifo_state_s;

  rcl_fifo_state_s state;
  rcl_fifo_state_s next_state;
  logic            doPush;
  logic            doPop;

  assign inReady  = (state.count != (PW+1)'(DEPTH));
  assign outValid = (state.count != '0);
  assign outData  = state.mem[state.rdPtr];
  assign doPush   = inValid && inReady;
  assign doPop    = outValid && outReady;

  always_comb begin
    next_state = state;
    if (doPush) begin
      next_state.mem[state.wrPtr] = inData;
      next_state.wrPtr = (state.wrPtr == PW'(DEPTH - 1)) ? '0 : state.wrPtr + 1'b1;
    end
    if (doPop) begin
      next_state.rdPtr = (state.rdPtr == PW'(DEPTH - 1)) ? '0 : state.rdPtr + 1'b1;
    end
    if (doPush && !doPop) begin
      next_state.count = state.count + 1'b1;
    end else if (doPop && !doPush) begin
      next_state.count = state.count - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
endmodule

// ============================================================
// Top level control
module rcl_output_rate_control #(
  parameter int QUEUE_DEPTH = 4
) (
  input  wire logic                 sys_clk,
  input  wire logic                 reset_n,
  input  wire logic                 modeSelectPin,
  input  wire logic                 sharedPinBypassMosi,
  input  wire logic                 sharedPinMuteSck,
  input  wire logic                 sharedPinClkEnSs,
  output logic                      misoOut,
  output logic                      misoOe,
  input  wire logic                 ratePinLow,
  input  wire logic                 ratePinHigh,
  input  wire logic                 referenceInputPin,
  input  wire logic                 pllLocked,
  input  wire logic                 rateSupported,
  input  wire logic                 fractionalRate,
  input  wire logic [2:0]           lockedRateCode,
  input  wire rcl_pkg::rcl_stream_s streamIn,
  output logic                      primarySerialOutput,
  output logic                      secondarySerialOutput,
  output rcl_pkg::rcl_src_e         primarySource,
  output rcl_pkg::rcl_src_e         secondarySource,
  output logic                      lockStatus,
  output logic                      standardDefinitionFlag,
  output rcl_pkg::rcl_rate_e        lockRateSelect,
  output logic                      eyeMonitorEnable,
  output logic                      reclockBypass,
  output logic                      writeQueueReady
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [7:0]  outputOverrideControl;
    logic [7:0]  outputFunctionControl;
    logic [7:0]  muxAndMuteLevelControl;
    logic [7:0]  lockRateSelectReg;
    logic [7:0]  lockRateOverride;
    logic [7:0]  manualOutputSelect;
    logic        modeMeta;
    logic        modeSync;
    logic [2:0]  pinMeta;
    logic [2:0]  pinSync;
    logic [1:0]  rateMeta;
    logic [1:0]  rateSync;
    logic        refMeta;
    logic        refSync;
    logic        refPrev;
    logic        sckPrev;
    logic [4:0]  bitCount;
    logic [15:0] rxShift;
    logic [7:0]  txShift;
    logic [10:0] refWindow;
    logic [10:0] refEdges;
    logic        referencePresentFlag;
  } rcl_state_s;

  rcl_state_s       state;
  rcl_state_s       next_state;
  rcl_pkg::rcl_wr_s pushWord;
  rcl_pkg::rcl_wr_s popWord;
  logic             pushValid;
  logic             popValid;
  logic             popReady;
  logic             regMode;
  logic             manualOverride;
  logic             bypassRequest;
  logic             muteRequest;
  logic             clockOutputEnable;
  logic             locked;
  logic             muteLevel;
  logic             sckRise;
  logic             sckFall;
  logic             frameActive;

  // ==========================================================
  // Source to level, shared by both outputs
  function automatic logic srcLevel(input rcl_pkg::rcl_src_e src,
                                    input rcl_pkg::rcl_stream_s s,
                                    input logic lvl);
    unique case (src)
      rcl_pkg::RCL_SRC_MUTED:     srcLevel = lvl;
      rcl_pkg::RCL_SRC_BYPASSED:  srcLevel = s.bypassData;
      rcl_pkg::RCL_SRC_RECLOCKED: srcLevel = s.reclockedData;
      rcl_pkg::RCL_SRC_CLOCK:     srcLevel = s.recoveredClock;
    endcase
  endfunction

  // Data source by lock state
  function automatic rcl_pkg::rcl_src_e dataByLock(input logic lk);
    dataByLock = lk ? rcl_pkg::RCL_SRC_RECLOCKED : rcl_pkg::RCL_SRC_BYPASSED;
  endfunction

  // ==========================================================
  // Control decode
  assign regMode        = state.modeSync;
  assign manualOverride = regMode && state.outputOverrideControl[`RCL_BIT_MANUAL_OV];
  // Bypass bit stays live under the manual override
  assign bypassRequest  = regMode ? state.outputFunctionControl[`RCL_BIT_BYPASS]
                                  : state.pinSync[0];
  assign muteRequest    = regMode ? (!manualOverride &&
                                     state.outputFunctionControl[`RCL_BIT_MUTE])
                                  : !state.pinSync[1];
  assign clockOutputEnable = regMode ? (!manualOverride &&
                                        state.outputFunctionControl[`RCL_BIT_CLK_EN])
                                     : state.pinSync[2];
  // An unsupported rate falls back to the raw path
  assign reclockBypass  = bypassRequest || !rateSupported;
  assign locked         = pllLocked && !reclockBypass;
  assign lockStatus     = locked;
  assign muteLevel      = state.muxAndMuteLevelControl[`RCL_BIT_MUTE_LEVEL];
  assign eyeMonitorEnable = !reclockBypass;
  assign standardDefinitionFlag = locked && (lockedRateCode == `RCL_RATE_CODE_270);

  // ==========================================================
  // Rate selection
  always_comb begin
    if (state.lockRateOverride[`RCL_BIT_RATE_OV]) begin
      lockRateSelect = rcl_pkg::rcl_rate_e'(state.lockRateSelectReg[1:0]);
    end else begin
      lockRateSelect = rcl_pkg::rcl_rate_e'(state.rateSync);
    end
  end

  // ==========================================================
  // Output routing, combinational so lock acts at once
  always_comb begin
    primarySource   = rcl_pkg::RCL_SRC_MUTED;
    secondarySource = rcl_pkg::RCL_SRC_MUTED;
    if (manualOverride) begin
      unique case (state.manualOutputSelect[`RCL_PRI_SEL_HI:`RCL_PRI_SEL_LO])
        2'h1:    primarySource = rcl_pkg::RCL_SRC_BYPASSED;
        2'h2:    primarySource = rcl_pkg::RCL_SRC_MUTED;
        default: primarySource = dataByLock(locked);
      endcase
      unique case (state.manualOutputSelect[`RCL_SEC_SEL_HI:`RCL_SEC_SEL_LO])
        2'h0:    secondarySource = locked ? rcl_pkg::RCL_SRC_CLOCK : rcl_pkg::RCL_SRC_MUTED;
        2'h1:    secondarySource = dataByLock(locked);
        2'h2:    secondarySource = rcl_pkg::RCL_SRC_MUTED;
        default: secondarySource = rcl_pkg::RCL_SRC_BYPASSED;
      endcase
    end else if (muteRequest) begin
      primarySource   = rcl_pkg::RCL_SRC_MUTED;
      secondarySource = rcl_pkg::RCL_SRC_MUTED;
    end else begin
      primarySource = dataByLock(locked);
      if (clockOutputEnable) begin
        // Bypass drops lock, so the clock output mutes under bypass too
        secondarySource = locked ? rcl_pkg::RCL_SRC_CLOCK : rcl_pkg::RCL_SRC_MUTED;
      end else begin
        secondarySource = dataByLock(locked);
      end
    end
  end

  assign primarySerialOutput   = srcLevel(primarySource, streamIn, muteLevel);
  assign secondarySerialOutput = srcLevel(secondarySource, streamIn, muteLevel);

  // ==========================================================
  // Serial register port on the shared pins
  assign sckRise     = regMode && state.pinSync[1] && !state.sckPrev;
  assign sckFall     = regMode && !state.pinSync[1] && state.sckPrev;
  assign frameActive = regMode && !state.pinSync[2];
  assign misoOut     = state.txShift[7];
  assign misoOe      = frameActive;
  assign pushWord.addr = state.rxShift[13:7];
  assign pushWord.data = {state.rxShift[6:0], state.pinSync[0]};
  assign pushValid   = sckRise && frameActive && !state.rxShift[14] &&
                       (state.bitCount == `RCL_FRAME_BITS - 5'h01);
  // Writes land between frames so reads never see half a burst
  assign popReady    = !frameActive;

  rcl_fifo #(
    .WIDTH ($bits(rcl_pkg::rcl_wr_s)),
    .DEPTH (QUEUE_DEPTH)
  ) writeQueue (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .inData   (pushWord),
    .inValid  (pushValid),
    .inReady  (writeQueueReady),
    .outData  (popWord),
    .outValid (popValid),
    .outReady (popReady)
  );

  // ==========================================================
  // Register read decode
  function automatic logic [7:0] regRead(input logic [6:0] addr,
                                         input rcl_state_s st,
                                         input logic lk,
                                         input logic frac);
    regRead = 8'h00;
    unique case (addr)
      `RCL_ADDR_LOCK_STATUS:   regRead[`RCL_BIT_LOCK] = lk;
      `RCL_ADDR_OVERRIDE_CTRL: regRead = st.outputOverrideControl;
      `RCL_ADDR_FUNCTION_CTRL: regRead = st.outputFunctionControl;
      `RCL_ADDR_MUX_MUTE_CTRL: regRead = st.muxAndMuteLevelControl;
      `RCL_ADDR_LOCK_RATE_SEL: regRead = st.lockRateSelectReg;
      `RCL_ADDR_LOCK_RATE_OV:  regRead = st.lockRateOverride;
      `RCL_ADDR_MANUAL_SEL:    regRead = st.manualOutputSelect;
      `RCL_ADDR_REF_STATUS: begin
        regRead[`RCL_BIT_REF_PRESENT] = st.referencePresentFlag;
        regRead[`RCL_BIT_ONE_OVER_M]  = st.referencePresentFlag && frac;
      end
      default: regRead = 8'h00;
    endcase
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    next_state = state;
    // Two flops on every pin
    next_state.modeMeta = modeSelectPin;
    next_state.modeSync = state.modeMeta;
    next_state.pinMeta  = {sharedPinClkEnSs, sharedPinMuteSck, sharedPinBypassMosi};
    next_state.pinSync  = state.pinMeta;
    next_state.rateMeta = {ratePinHigh, ratePinLow};
    next_state.rateSync = state.rateMeta;
    next_state.refMeta  = referenceInputPin;
    next_state.refSync  = state.refMeta;
    next_state.refPrev  = state.refSync;
    next_state.sckPrev  = state.pinSync[1];

    // Frame bit counter and shifters
    if (!frameActive) begin
      next_state.bitCount = 5'h00;
    end else if (sckRise) begin
      next_state.rxShift  = {state.rxShift[14:0], state.pinSync[0]};
      next_state.bitCount = state.bitCount + 5'h01;
      if (state.bitCount == `RCL_HEADER_BITS - 5'h01) begin
        next_state.txShift = regRead({state.rxShift[5:0], state.pinSync[0]},
                                     state, locked, fractionalRate);
      end
    end else if (sckFall && state.bitCount > `RCL_HEADER_BITS) begin
      next_state.txShift = {state.txShift[6:0], 1'b0};
    end

    // Register writes drained from the queue
    if (popValid && popReady) begin
      unique case (popWord.addr)
        `RCL_ADDR_OVERRIDE_CTRL: next_state.outputOverrideControl  = popWord.data;
        `RCL_ADDR_FUNCTION_CTRL: next_state.outputFunctionControl  = popWord.data;
        `RCL_ADDR_MUX_MUTE_CTRL: next_state.muxAndMuteLevelControl = popWord.data;
        `RCL_ADDR_LOCK_RATE_SEL: next_state.lockRateSelectReg      = popWord.data;
        `RCL_ADDR_LOCK_RATE_OV:  next_state.lockRateOverride       = popWord.data;
        `RCL_ADDR_MANUAL_SEL:    next_state.manualOutputSelect     = popWord.data;
        default: ;
      endcase
    end

    // Reference: rising edges per window
    if (state.refSync && !state.refPrev) begin
      next_state.refEdges = state.refEdges + 11'h001;
    end
    if (state.refWindow == 11'(`RCL_REF_WINDOW_CYCLES - 1)) begin
      next_state.refWindow = 11'h000;
      next_state.refEdges  = 11'h000;
      next_state.referencePresentFlag = (state.refEdges >= 11'(`RCL_REF_MIN_EDGES));
    end else begin
      next_state.refWindow = state.refWindow + 11'h001;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= '0;
      state.outputOverrideControl  <= `RCL_REG_RESET;
      state.outputFunctionControl  <= `RCL_REG_RESET;
      state.muxAndMuteLevelControl <= `RCL_REG_RESET;
      state.lockRateSelectReg      <= `RCL_REG_RESET;
      state.lockRateOverride       <= `RCL_REG_RESET;
      state.manualOutputSelect     <= `RCL_REG_RESET;
      // Pins idle unmuted and deselected until synced
      state.pinMeta <= 3'h6;
      state.pinSync <= 3'h6;
      state.sckPrev <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

endmodule

// >>> bench/rcl_output_rate_control_properties.sv
// Port checker for the rate control block
`timescale 1ns/100ps

// ==========================================================
// Checker
module rcl_output_rate_control_checker (
  input logic                 sys_clk,
  input logic                 reset_n,
  input logic                 modeSelectPin,
  input logic                 sharedPinBypassMosi,
  input logic                 sharedPinMuteSck,
  input logic                 misoOe,
  input logic                 pllLocked,
  input logic                 rateSupported,
  input logic [2:0]           lockedRateCode,
  input rcl_pkg::rcl_stream_s streamIn,
  input logic                 primarySerialOutput,
  input logic                 secondarySerialOutput,
  input rcl_pkg::rcl_src_e    primarySource,
  input rcl_pkg::rcl_src_e    secondarySource,
  input logic                 lockStatus,
  input logic                 standardDefinitionFlag,
  input logic                 eyeMonitorEnable,
  input logic                 reclockBypass
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  property p_sd_flag;
    standardDefinitionFlag == (lockStatus && lockedRateCode == 3'h1);
  endproperty
  a_sd_flag: assert property (p_sd_flag) else $error("sd flag wrong");

  property p_lock;
    lockStatus == (pllLocked && !reclockBypass);
  endproperty
  a_lock: assert property (p_lock) else $error("lock wrong");

  property p_unsupported;
    !rateSupported |-> reclockBypass;
  endproperty
  a_unsupported: assert property (p_unsupported) else $error("no auto bypass");

  property p_eye;
    eyeMonitorEnable == !reclockBypass;
  endproperty
  a_eye: assert property (p_eye) else $error("eye monitor on");

  property p_clock_src;
    secondarySource == rcl_pkg::RCL_SRC_CLOCK
      |-> lockStatus && secondarySerialOutput == streamIn.recoveredClock;
  endproperty
  a_clock_src: assert property (p_clock_src) else $error("clock out wrong");

  property p_recl_src;
    primarySource == rcl_pkg::RCL_SRC_RECLOCKED
      |-> lockStatus && primarySerialOutput == streamIn.reclockedData;
  endproperty
  a_recl_src: assert property (p_recl_src) else $error("reclocked wrong");

  property p_byp_src;
    primarySource == rcl_pkg::RCL_SRC_BYPASSED |-> primarySerialOutput == streamIn.bypassData;
  endproperty
  a_byp_src: assert property (p_byp_src) else $error("bypass out wrong");

  property p_no_clock_primary;
    primarySource != rcl_pkg::RCL_SRC_CLOCK;
  endproperty
  a_no_clock_primary: assert property (p_no_clock_primary) else $error("clock on primary");

  // Two-flop pin sync needs three steady cycles; the check waits four
  property p_pin_mute;
    (!modeSelectPin && !sharedPinMuteSck) [*4] |-> primarySource == rcl_pkg::RCL_SRC_MUTED
      && secondarySource == rcl_pkg::RCL_SRC_MUTED;
  endproperty
  a_pin_mute: assert property (p_pin_mute) else $error("mute pin ignored");

  property p_pin_bypass;
    (!modeSelectPin && sharedPinBypassMosi && sharedPinMuteSck) [*4]
      |-> reclockBypass && !lockStatus && primarySource == rcl_pkg::RCL_SRC_BYPASSED;
  endproperty
  a_pin_bypass: assert property (p_pin_bypass) else $error("bypass pin ignored");

  property p_pin_miso;
    !modeSelectPin [*4] |-> !misoOe;
  endproperty
  a_pin_miso: assert property (p_pin_miso) else $error("serial out in pin mode");
endmodule

bind rcl_output_rate_control rcl_output_rate_control_checker u_rcl_output_rate_control_checker (.*);

// >>> bench/rcl_host_model.sv
// Serial host for register mode
`timescale 1ns/100ps

// ==========================================================
// Host
module rcl_host_model (
  input wire logic sys_clk,
  input wire logic miso,
  output logic     mosi,
  output logic     sck,
  output logic     selectN
);
  // Six-cycle half period clears the edge detect
  localparam int HALF = 6;

  initial begin
    mosi = 1'b0;
    sck = 1'b0;
    selectN = 1'b1;
  end

  // Data line is not held while deselected
  always @(posedge sys_clk) begin
    if (selectN) mosi <= ~mosi;
  end

  // One frame: read flag, address, data, MSB first
  task automatic frame(input logic rd, input logic [6:0] addr, input logic [7:0] wdata,
                       output logic [7:0] rdata);
    logic [15:0] bits;
    bits = {rd, addr, wdata};
    rdata = 8'h00;
    @(posedge sys_clk);
    selectN <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      @(posedge sys_clk);
      mosi <= bits[i];
      repeat (HALF - 1) @(posedge sys_clk);
      @(negedge sys_clk);
      if (i < 8) rdata = {rdata[6:0], miso};
      @(posedge sys_clk);
      sck <= 1'b1;
      repeat (HALF) @(posedge sys_clk);
      sck <= 1'b0;
    end
    repeat (HALF) @(posedge sys_clk);
    selectN <= 1'b1;
    repeat (2 * HALF) @(posedge sys_clk);
  endtask
endmodule

// >>> bench/rcl_output_rate_control_tb_top.sv
// Self-checking bench for the rate control block
`timescale 1ns/100ps

// ==========================================================
// Bench top
module rcl_output_rate_control_tb_top;
  logic sys_clk = 1'b0, reset_n = 1'b0, modeSel = 1'b0, pinByp = 1'b0, pinMute = 1'b1;
  logic pinClkEn = 1'b0, rateLo = 1'b0, rateHi = 1'b0, refPin = 1'b0, refOn = 1'b0;
  logic pllLocked = 1'b0, rateSupported = 1'b1, fracRate = 1'b0, idleToggle = 1'b0;
  logic [2:0] lockedRate = 3'h0;
  rcl_pkg::rcl_stream_s stream = '0;
  logic hostMosi, hostSck, hostSelN, misoOut, misoOe, priOut, secOut, lockStatus, sdFlag;
  logic eyeOn, bypassOut, queueReady;
  rcl_pkg::rcl_src_e priSrc, secSrc;
  rcl_pkg::rcl_rate_e rateSel;
  int miscompares = 0, samplesChecked = 0, expLock = 0;
  int rOv = 0, rFn = 0, rMux = 0, rRate = 0, rRateOv = 0, rSel = 0;
  logic [6:0] rndAddr[4] = '{7'h12, 7'h14, 7'h1c, 7'h1d};

  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) idleToggle <= ~idleToggle;
  // Roughly 27 MHz; grounded while absent
  always #18.5 refPin = refOn ? ~refPin : 1'b0;

  rcl_host_model u_rcl_host_model (.sys_clk(sys_clk), .miso(misoOe ? misoOut : idleToggle),
    .mosi(hostMosi), .sck(hostSck), .selectN(hostSelN));

  rcl_output_rate_control u_rcl_output_rate_control (.sys_clk(sys_clk), .reset_n(reset_n),
    .modeSelectPin(modeSel), .sharedPinBypassMosi(modeSel ? hostMosi : pinByp),
    .sharedPinMuteSck(modeSel ? hostSck : pinMute),
    .sharedPinClkEnSs(modeSel ? hostSelN : pinClkEn), .misoOut(misoOut), .misoOe(misoOe),
    .ratePinLow(rateLo), .ratePinHigh(rateHi), .referenceInputPin(refPin),
    .pllLocked(pllLocked), .rateSupported(rateSupported), .fractionalRate(fracRate),
    .lockedRateCode(lockedRate), .streamIn(stream), .primarySerialOutput(priOut),
    .secondarySerialOutput(secOut), .primarySource(priSrc), .secondarySource(secSrc),
    .lockStatus(lockStatus), .standardDefinitionFlag(sdFlag), .lockRateSelect(rateSel),
    .eyeMonitorEnable(eyeOn), .reclockBypass(bypassOut), .writeQueueReady(queueReady));

  task automatic finishTest();
    $display("checks %0d mismatches %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic compare(input string name, logic [7:0] seen, exp);
    samplesChecked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic pick(int s);
    case (s)
      0: return rMux[7];
      1: return stream.bypassData;
      2: return stream.reclockedData;
      default: return stream.recoveredClock;
    endcase
  endfunction

  // Routing model
  task automatic checkAll();
    int ovr, byp, mute, clkEn, ps, ss;
    ovr = modeSel && rOv[5];
    byp = (modeSel ? rFn[2] : pinByp) || !rateSupported;
    expLock = pllLocked && !byp;
    mute = !ovr && (modeSel ? rFn[1] : !pinMute);
    clkEn = !ovr && (modeSel ? rFn[0] : pinClkEn);
    ps = expLock ? 2 : 1;
    ss = clkEn ? (expLock ? 3 : 0) : ps;
    if (ovr) begin
      ps = (rSel[6:5] == 2) ? 0 : (rSel[6:5] == 1) ? 1 : (expLock ? 2 : 1);
      ss = (rSel[4:3] == 0) ? (expLock ? 3 : 0) : (rSel[4:3] == 1) ? (expLock ? 2 : 1)
         : (rSel[4:3] == 2) ? 0 : 1;
    end
    if (mute) begin
      ps = 0;
      ss = 0;
    end
    compare("primary source", 8'(priSrc), 8'(ps));
    compare("secondary source", 8'(secSrc), 8'(ss));
    compare("outputs", {6'h00, priOut, secOut}, {6'h00, pick(ps), pick(ss)});
    compare("lock", 8'(lockStatus), 8'(expLock));
    compare("bypass", {6'h00, bypassOut, eyeOn}, {6'h00, 1'(byp), 1'(!byp)});
    compare("sd flag", 8'(sdFlag), 8'(expLock && lockedRate == 3'h1));
    compare("rate", 8'(rateSel), 8'(rRateOv[0] ? rRate[1:0] : {rateHi, rateLo}));
  endtask

  task automatic readCheck(input logic [6:0] addr, input logic [7:0] exp);
    logic [7:0] got;
    u_rcl_host_model.frame(1'b1, addr, 8'h00, got);
    compare("register", got, exp);
  endtask

  task automatic writeReg(input logic [6:0] addr, input logic [7:0] data);
    logic [7:0] unused;
    for (int n = 0; !queueReady; n++) begin
      if (n > 100) begin
        miscompares++;
        finishTest();
      end
      @(posedge sys_clk);
    end
    u_rcl_host_model.frame(1'b0, addr, data, unused);
    case (addr)
      7'h09: rOv = data;
      7'h12: rFn = data;
      7'h14: rMux = data;
      7'h1c: rRate = data;
      7'h1d: rRateOv = data;
      7'h1e: rSel = data;
      default: ;
    endcase
  endtask

  initial begin
    void'($urandom(32'hf1a79dc9));
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    // Pin mode sweep
    for (int i = 0; i < 64; i++) begin
      @(posedge sys_clk);
      {pinByp, pinMute, pinClkEn, rateLo, rateHi, pllLocked, rateSupported} <= 7'($urandom);
      lockedRate <= ($urandom % 2) ? 3'h1 : 3'($urandom);
      stream <= 3'($urandom);
      repeat (5) @(posedge sys_clk);
      @(negedge sys_clk) checkAll();
    end
    @(posedge sys_clk);
    modeSel <= 1'b1;
    repeat (8) @(posedge sys_clk);
    readCheck(7'h09, 8'h00);
    readCheck(7'h12, 8'h00);
    readCheck(7'h1e, 8'h00);
    readCheck(7'h55, 8'h00);
    writeReg(7'h41, 8'hff);
    readCheck(7'h41, 8'h00);
    // Register mode: every manual select pair, then plain control
    for (int i = 0; i < 20; i++) begin
      writeReg(7'h09, (8'($urandom) & 8'hdf) | (i < 16 ? 8'h20 : 8'h00));
      foreach (rndAddr[a]) writeReg(rndAddr[a], 8'($urandom));
      writeReg(7'h1e, (8'($urandom) & 8'h87) | (8'(i % 16) << 3));
      for (int k = 0; k < 4; k++) begin
        @(posedge sys_clk);
        {pllLocked, rateSupported} <= 2'(k);
        lockedRate <= 3'(k % 2);
        stream <= 3'($urandom);
        @(negedge sys_clk) checkAll();
      end
      readCheck(7'h01, 8'(expLock) << 4);
      readCheck(7'h1e, 8'(rSel));
    end
    fracRate <= 1'b1;
    refOn = 1'b1;
    repeat (2200) @(posedge sys_clk);
    readCheck(7'h41, 8'h0c);
    refOn = 1'b0;
    repeat (2200) @(posedge sys_clk);
    readCheck(7'h41, 8'h00);
    finishTest();
  end
endmodule
